//--- bwm_defs.svh
// constants of the breaker wear monitor
`ifndef BWM_DEFS_SVH
`define BWM_DEFS_SVH
`define BWM_CUR_W 14
`define BWM_CNT_W 17
`define BWM_LG_W 19
`define BWM_POINTS 8
`define BWM_TRIPS 8
`define BWM_SEL_W 3
`define BWM_PHASES 3
`define BWM_ALARMS 2
`define BWM_LOGS 5
`define BWM_CUR_MAX 14'h2710
`define BWM_LIM_MIN 17'h00001
`define BWM_LIM_MAX 17'h186a0
`define BWM_OPS_RESET 17'h00000
`define BWM_CNT_SAT 17'h1ffff
`define BWM_ONE_Q16 17'h10000
`define BWM_HALF_Q16 35'h000008000
`define BWM_ITER_LAST 4'hb
`define BWM_LIDX_LAST 3'h4
`define BWM_STEP_PHASE 4'h2
`define BWM_STEP_EXP 4'h5
`define BWM_STEP_LAST 4'ha
`define BWM_STEP_CLR_LAST 4'h1
`endif

//--- bwm_pkg.sv
// types of the breaker wear monitor
`include "bwm_defs.svh"
package bwm_pkg;
  typedef logic [`BWM_CUR_W-1:0]        current_t;
  typedef logic [`BWM_CNT_W-1:0]        count_t;
  typedef logic signed [`BWM_LG_W-1:0]  lg_t;
  typedef enum logic {OP_INTERP = 1'b0, OP_EXP = 1'b1} calc_op_t;
  typedef enum logic [2:0] {
    C_IDLE = 3'b000, C_LOAD = 3'b001, C_LOG = 3'b010, C_DIV = 3'b011,
    C_EXPL = 3'b100, C_EXP = 3'b101, C_FIN = 3'b110, C_DONE = 3'b111
  } calc_state_t;
  typedef enum logic [1:0] {
    M_IDLE = 2'b00, M_REQ = 2'b01, M_WAIT = 2'b10, M_APPLY = 2'b11
  } mon_state_t;
  typedef enum logic {JOB_TRIP = 1'b0, JOB_CLEAR = 1'b1} job_t;
endpackage

//--- wear_calc_if.sv
// request and answer between the wear monitor and the curve calculator
`timescale 1ns/1ns
`default_nettype none
interface wear_calc_if;
  logic              req;
  bwm_pkg::calc_op_t op;
  bwm_pkg::current_t cur;
  bwm_pkg::lg_t      lg_in;
  logic              done;
  bwm_pkg::lg_t      lg_out;
  bwm_pkg::count_t   cnt_out;
  modport requester (output req, op, cur, lg_in, input done, lg_out, cnt_out);
  modport calc (input req, op, cur, lg_in, output done, lg_out, cnt_out);
endinterface
`default_nettype wire

//--- wear_curve_calc.sv
// log/log curve interpolation and base-2 power for the wear monitor
`timescale 1ns/1ns
`default_nettype none
`include "bwm_defs.svh"
module wear_curve_calc (
  input  wire logic              clock,
  input  wire logic              resetn,
  wear_calc_if.calc              calc,
  input  wire bwm_pkg::current_t curve_current [`BWM_POINTS],
  input  wire bwm_pkg::count_t   curve_count   [`BWM_POINTS]
);
  localparam int CALC_MAX = 100;
  bwm_pkg::calc_state_t state_ff;
  bwm_pkg::current_t    cur_ff;
  bwm_pkg::lg_t         lgs_ff [`BWM_LOGS];
  bwm_pkg::lg_t         res_ff;
  bwm_pkg::count_t      cnt_ff;
  logic [16:0]          m_ff;
  logic [16:0]          acc_ff;
  logic [4:0]           int_ff;
  logic [11:0]          fbits_ff;
  logic [3:0]           it_ff;
  logic [2:0]           lidx_ff;

  // 2^(2^-(i+1)) in Q1.16
  function automatic logic [16:0] kroot(input logic [3:0] i);
    unique case (i)
      4'h0: kroot = 17'h16a0a;
      4'h1: kroot = 17'h13070;
      4'h2: kroot = 17'h1172c;
      4'h3: kroot = 17'h10b56;
      4'h4: kroot = 17'h1059b;
      4'h5: kroot = 17'h102c9;
      4'h6: kroot = 17'h10164;
      4'h7: kroot = 17'h100b2;
      4'h8: kroot = 17'h10059;
      4'h9: kroot = 17'h1002c;
      4'ha: kroot = 17'h10016;
      4'hb: kroot = 17'h1000b;
      default: kroot = `BWM_ONE_Q16;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // segment search: highest point at or below the current
  logic [`BWM_POINTS-1:0] hit;
  logic [2:0]             seg_k;
  genvar g;
  generate
    for (g = 0; g < `BWM_POINTS; g++) begin : g_hit
      assign hit[g] = cur_ff >= curve_current[g];
    end
  endgenerate
  always_comb begin
    seg_k = 3'h1;
    for (int k = 1; k < `BWM_POINTS - 1; k++) begin
      if (hit[k]) begin
        seg_k = 3'(k);
      end
    end
  end
  wire logic [2:0] seg_k1 = seg_k + 3'h1;
  wire logic       below  = !hit[1];
  wire logic       above  = hit[`BWM_POINTS-1];

  ////////////////////////////////////////////////////////////////////////////
  // base-2 logarithm by repeated squaring, 12 fraction bits
  wire logic [16:0] opnd = (lidx_ff == 3'h0) ? {3'h0, cur_ff} :
                           (lidx_ff == 3'h1) ? {3'h0, curve_current[seg_k]} :
                           (lidx_ff == 3'h2) ? {3'h0, curve_current[seg_k1]} :
                           (lidx_ff == 3'h3) ? curve_count[seg_k] : curve_count[seg_k1];
  wire logic [16:0] xin = (opnd == 17'h0) ? 17'h1 : opnd;
  logic [4:0] msb;
  always_comb begin
    msb = 5'h0;
    for (int i = 0; i < 17; i++) begin
      if (xin[i]) begin
        msb = 5'(i);
      end
    end
  end
  wire logic [16:0] norm   = 17'(xin << (5'd16 - msb));
  wire logic [33:0] sq     = m_ff * m_ff;
  wire logic [16:0] m_nxt  = sq[33] ? sq[33:17] : sq[32:16];
  wire logic [11:0] f_nxt  = {fbits_ff[10:0], sq[33]};
  wire bwm_pkg::lg_t lg_new = {2'b00, int_ff, f_nxt};

  ////////////////////////////////////////////////////////////////////////////
  // interpolation on log/log axes: logC = logCk - dC*dI/dS
  wire bwm_pkg::lg_t dc = lgs_ff[3] - lgs_ff[4];
  wire bwm_pkg::lg_t di = lgs_ff[0] - lgs_ff[1];
  wire bwm_pkg::lg_t ds = lgs_ff[2] - lgs_ff[1];
  wire logic signed [37:0] prod = 38'(dc) * 38'(di);
  wire logic signed [37:0] quo  = (ds == 19'sh0) ? 38'sh0 : prod / 38'(ds);
  wire bwm_pkg::lg_t interp  = lgs_ff[3] - 19'(quo);
  wire bwm_pkg::lg_t res_div = above ? lgs_ff[4] : (below ? lgs_ff[3] : interp);

  ////////////////////////////////////////////////////////////////////////////
  // power of two, rounded to whole operations
  wire bwm_pkg::lg_t e_pos  = res_ff[18] ? 19'sh0 : res_ff;
  wire logic [4:0]   e_int  = e_pos[16:12];
  wire logic [11:0]  e_frac = e_pos[11:0];
  wire logic [33:0]  mul    = acc_ff * kroot(it_ff);
  wire logic [16:0]  acc_nx = e_frac[4'hb - it_ff] ? mul[32:16] : acc_ff;
  wire logic [34:0]  shl    = 35'(acc_ff) << e_int;
  wire logic [34:0]  rnd    = shl + `BWM_HALF_Q16;
  wire bwm_pkg::count_t cnt_fin = (|rnd[34:33]) ? `BWM_CNT_SAT : rnd[32:16];

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_ff <= bwm_pkg::C_IDLE;
      cur_ff   <= '0;
      lgs_ff   <= '{default: '0};
      res_ff   <= '0;
      cnt_ff   <= '0;
      m_ff     <= '0;
      acc_ff   <= '0;
      int_ff   <= '0;
      fbits_ff <= '0;
      it_ff    <= '0;
      lidx_ff  <= '0;
    end else begin
      unique case (state_ff)
        bwm_pkg::C_IDLE: if (calc.req) begin
          cur_ff   <= calc.cur;
          lidx_ff  <= 3'h0;
          res_ff   <= calc.lg_in;
          state_ff <= (calc.op == bwm_pkg::OP_EXP) ? bwm_pkg::C_EXPL : bwm_pkg::C_LOAD;
        end
        bwm_pkg::C_LOAD: begin
          m_ff     <= norm;
          int_ff   <= msb;
          fbits_ff <= 12'h0;
          it_ff    <= 4'h0;
          state_ff <= bwm_pkg::C_LOG;
        end
        bwm_pkg::C_LOG: begin
          m_ff     <= m_nxt;
          fbits_ff <= f_nxt;
          it_ff    <= it_ff + 4'h1;
          if (it_ff == `BWM_ITER_LAST) begin
            lgs_ff[lidx_ff] <= lg_new;
            lidx_ff         <= lidx_ff + 3'h1;
            state_ff <= (lidx_ff == `BWM_LIDX_LAST) ? bwm_pkg::C_DIV : bwm_pkg::C_LOAD;
          end
        end
        bwm_pkg::C_DIV: begin
          res_ff   <= res_div;
          state_ff <= bwm_pkg::C_EXPL;
        end
        bwm_pkg::C_EXPL: begin
          acc_ff   <= `BWM_ONE_Q16;
          it_ff    <= 4'h0;
          state_ff <= bwm_pkg::C_EXP;
        end
        bwm_pkg::C_EXP: begin
          acc_ff   <= acc_nx;
          it_ff    <= it_ff + 4'h1;
          if (it_ff == `BWM_ITER_LAST) begin
            state_ff <= bwm_pkg::C_FIN;
          end
        end
        bwm_pkg::C_FIN: begin
          cnt_ff   <= cnt_fin;
          state_ff <= bwm_pkg::C_DONE;
        end
        bwm_pkg::C_DONE: state_ff <= bwm_pkg::C_IDLE;
      endcase
    end
  end

  assign calc.done    = state_ff == bwm_pkg::C_DONE;
  assign calc.lg_out  = res_ff;
  assign calc.cnt_out = cnt_ff;

  calc_latency_a: assert property (@(posedge clock) disable iff (!resetn)
    (calc.req && state_ff == bwm_pkg::C_IDLE) |-> ##[1:CALC_MAX] calc.done)
    else $error("curve calculation did not finish in time");
endmodule // wear_curve_calc
`default_nettype wire

//--- breaker_wear_monitor.sv
// breaker wear monitor: trip capture, wear counters, alarms and events
// Contract
// - per-pole broken current drives wear estimate
// - capture pole currents when supervised trip rises
// - curve table holds up to eight points
// - log interpolation between defined points two-eight
// - C equals a over I to n
// - two alarm points, current and limit each
// - each trip weighs current against both alarms
// - alarm active when count below limit
// - active alarm drives output matrix signal
// - events only when matching enable set
// - clear reloads counters with alarm-level maximum
// - three readable counters per alarm, six total
// - alarm compares minimum of three phases
// - decrement is count ratio, one below alarm
// - alarm current and limit ranges enforced
// - separate rise and fall event enables
`timescale 1ns/1ns
`default_nettype none
`include "bwm_defs.svh"
module breaker_wear_monitor (
  input  wire logic                   clock,
  input  wire logic                   resetn,
  input  wire logic [`BWM_TRIPS-1:0]  trip_outputs,
  input  wire logic [`BWM_SEL_W-1:0]  supervised_trip_output_select,
  input  wire bwm_pkg::current_t      phase_current    [`BWM_PHASES],
  input  wire bwm_pkg::current_t      curve_current    [`BWM_POINTS],
  input  wire bwm_pkg::count_t        curve_count      [`BWM_POINTS],
  input  wire bwm_pkg::current_t      alarm_current    [`BWM_ALARMS],
  input  wire bwm_pkg::count_t        alarm_limit      [`BWM_ALARMS],
  input  wire logic                   alarm_one_rise_event_en,
  input  wire logic                   alarm_one_fall_event_en,
  input  wire logic                   alarm_two_rise_event_en,
  input  wire logic                   alarm_two_fall_event_en,
  input  wire logic                   clear_cmd,
  output bwm_pkg::count_t             ops_left_alarm_one_phase [`BWM_PHASES],
  output bwm_pkg::count_t             ops_left_alarm_two_phase [`BWM_PHASES],
  output bwm_pkg::current_t           last_break_current       [`BWM_PHASES],
  output logic                        alarm_one_out,
  output logic                        alarm_two_out,
  output logic                        alarm_one_rise_event,
  output logic                        alarm_one_fall_event,
  output logic                        alarm_two_rise_event,
  output logic                        alarm_two_fall_event,
  output logic                        busy
);
  bwm_pkg::mon_state_t state_ff;
  bwm_pkg::job_t       job_ff;
  logic [3:0]          step_ff;
  logic                trip_prev_ff;
  logic                trip_pend_ff;
  logic                clr_pend_ff;
  bwm_pkg::current_t   cap_ff   [`BWM_PHASES];
  bwm_pkg::current_t   brk_ff   [`BWM_PHASES];
  bwm_pkg::lg_t        lg_ff    [`BWM_LOGS];
  bwm_pkg::count_t     cnt_a_ff [`BWM_ALARMS];
  bwm_pkg::count_t     delta_ff;
  bwm_pkg::count_t     ops_ff   [`BWM_ALARMS][`BWM_PHASES];
  logic [1:0]          alarm_ff;
  logic [1:0]          rise_ev_ff;
  logic [1:0]          fall_ev_ff;

  wear_calc_if calc_bus ();

  wear_curve_calc u_calc (
    .clock         (clock),
    .resetn        (resetn),
    .calc          (calc_bus.calc),
    .curve_current (curve_current),
    .curve_count   (curve_count)
  );

  ////////////////////////////////////////////////////////////////////////////
  // supervised trip output and pending work, set wins over clear
  wire logic sel_trip  = trip_outputs[supervised_trip_output_select];
  wire logic trip_rise = sel_trip && !trip_prev_ff;
  wire logic start_clr  = (state_ff == bwm_pkg::M_IDLE) && clr_pend_ff;
  wire logic start_trip = (state_ff == bwm_pkg::M_IDLE) && !clr_pend_ff && trip_pend_ff;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      trip_prev_ff <= 1'b0;
      trip_pend_ff <= 1'b0;
      clr_pend_ff  <= 1'b0;
      cap_ff       <= '{default: '0};
    end else begin
      trip_prev_ff <= sel_trip;
      trip_pend_ff <= trip_rise || (trip_pend_ff && !start_trip);
      clr_pend_ff  <= clear_cmd || (clr_pend_ff && !start_clr);
      if (trip_rise) begin
        cap_ff <= phase_current;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // step decode: 0-1 alarm levels, 2-4 phases, 5-10 ratio per alarm and phase
  wire logic [3:0] step_m5 = step_ff - `BWM_STEP_EXP;
  wire logic       sel_a   = step_m5 >= 4'h3;
  wire logic [1:0] sel_p   = 2'(sel_a ? step_m5 - 4'h3 : step_m5);
  bwm_pkg::current_t alarm_eff [`BWM_ALARMS];
  bwm_pkg::count_t   lim_eff   [`BWM_ALARMS];
  bwm_pkg::count_t   min_ops   [`BWM_ALARMS];
  wire bwm_pkg::current_t step_cur =
    (step_ff < `BWM_STEP_PHASE) ? alarm_eff[step_ff[0]] : brk_ff[2'(step_ff - `BWM_STEP_PHASE)];
  wire logic       is_exp    = step_ff >= `BWM_STEP_EXP;
  wire logic       below_sel = brk_ff[sel_p] < alarm_eff[sel_a];
  wire bwm_pkg::count_t cur_ops = ops_ff[sel_a][sel_p];
  wire bwm_pkg::count_t dec     = below_sel ? 17'h00001 : delta_ff;
  wire bwm_pkg::count_t ops_dec = (dec >= cur_ops) ? 17'h00000 : cur_ops - dec;
  wire logic apply_trip  = (state_ff == bwm_pkg::M_APPLY) && (job_ff == bwm_pkg::JOB_TRIP) && is_exp;
  wire logic apply_clear = (state_ff == bwm_pkg::M_APPLY) && (job_ff == bwm_pkg::JOB_CLEAR)
                           && (step_ff == `BWM_STEP_CLR_LAST);
  wire logic last_step = (job_ff == bwm_pkg::JOB_CLEAR) ? step_ff == `BWM_STEP_CLR_LAST
                                                        : step_ff == `BWM_STEP_LAST;

  assign calc_bus.req   = state_ff == bwm_pkg::M_REQ;
  assign calc_bus.op    = is_exp ? bwm_pkg::OP_EXP : bwm_pkg::OP_INTERP;
  assign calc_bus.cur   = step_cur;
  // ratio of permitted counts as a difference of logarithms
  assign calc_bus.lg_in = lg_ff[sel_a] - lg_ff[3'(sel_p) + 3'h2];

  ////////////////////////////////////////////////////////////////////////////
  // sequencer
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_ff <= bwm_pkg::M_IDLE;
      job_ff   <= bwm_pkg::JOB_TRIP;
      step_ff  <= 4'h0;
      brk_ff   <= '{default: '0};
    end else begin
      unique case (state_ff)
        bwm_pkg::M_IDLE: begin
          step_ff <= 4'h0;
          if (start_clr) begin
            job_ff   <= bwm_pkg::JOB_CLEAR;
            state_ff <= bwm_pkg::M_REQ;
          end else if (start_trip) begin
            job_ff   <= bwm_pkg::JOB_TRIP;
            brk_ff   <= cap_ff;
            state_ff <= bwm_pkg::M_REQ;
          end
        end
        bwm_pkg::M_REQ:  state_ff <= bwm_pkg::M_WAIT;
        bwm_pkg::M_WAIT: if (calc_bus.done) begin
          state_ff <= bwm_pkg::M_APPLY;
        end
        bwm_pkg::M_APPLY: begin
          step_ff  <= step_ff + 4'h1;
          state_ff <= last_step ? bwm_pkg::M_IDLE : bwm_pkg::M_REQ;
        end
      endcase
    end
  end

  // results of the calculator
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      lg_ff    <= '{default: '0};
      cnt_a_ff <= '{default: '0};
      delta_ff <= '0;
    end else if (state_ff == bwm_pkg::M_WAIT && calc_bus.done) begin
      if (!is_exp) begin
        lg_ff[3'(step_ff)] <= calc_bus.lg_out;
      end
      if (step_ff < `BWM_STEP_PHASE) begin
        cnt_a_ff[step_ff[0]] <= calc_bus.cnt_out;
      end
      delta_ff <= calc_bus.cnt_out;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per alarm point: limits, counters, minimum, alarm and events
  wire logic [1:0] rise_en = {alarm_two_rise_event_en, alarm_one_rise_event_en};
  wire logic [1:0] fall_en = {alarm_two_fall_event_en, alarm_one_fall_event_en};
  genvar a;
  generate
    for (a = 0; a < `BWM_ALARMS; a++) begin : g_alarm
      // settings are held inside their ranges
      assign alarm_eff[a] = (alarm_current[a] > `BWM_CUR_MAX) ? `BWM_CUR_MAX : alarm_current[a];
      assign lim_eff[a]   = (alarm_limit[a] < `BWM_LIM_MIN) ? `BWM_LIM_MIN :
                            (alarm_limit[a] > `BWM_LIM_MAX) ? `BWM_LIM_MAX : alarm_limit[a];
      wire bwm_pkg::count_t m01 = (ops_ff[a][1] < ops_ff[a][0]) ? ops_ff[a][1] : ops_ff[a][0];
      assign min_ops[a] = (ops_ff[a][2] < m01) ? ops_ff[a][2] : m01;
      wire logic alarm_nxt = min_ops[a] < lim_eff[a];
      for (genvar p = 0; p < `BWM_PHASES; p++) begin : g_phase
        always_ff @(posedge clock or negedge resetn) begin
          if (!resetn) begin
            ops_ff[a][p] <= `BWM_OPS_RESET;
          end else if (apply_clear) begin
            ops_ff[a][p] <= cnt_a_ff[a];
          end else if (apply_trip && sel_a == 1'(a) && sel_p == 2'(p)) begin
            ops_ff[a][p] <= ops_dec;
          end
        end
      end
      always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
          alarm_ff[a]   <= 1'b0;
          rise_ev_ff[a] <= 1'b0;
          fall_ev_ff[a] <= 1'b0;
        end else begin
          alarm_ff[a]   <= alarm_nxt;
          rise_ev_ff[a] <= alarm_nxt && !alarm_ff[a] && rise_en[a];
          fall_ev_ff[a] <= !alarm_nxt && alarm_ff[a] && fall_en[a];
        end
      end
    end
  endgenerate

  assign ops_left_alarm_one_phase = ops_ff[0];
  assign ops_left_alarm_two_phase = ops_ff[1];
  assign last_break_current       = cap_ff;
  assign alarm_one_out            = alarm_ff[0];
  assign alarm_two_out            = alarm_ff[1];
  assign alarm_one_rise_event     = rise_ev_ff[0];
  assign alarm_two_rise_event     = rise_ev_ff[1];
  assign alarm_one_fall_event     = fall_ev_ff[0];
  assign alarm_two_fall_event     = fall_ev_ff[1];
  assign busy                     = state_ff != bwm_pkg::M_IDLE;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  sequence s_trip_start;
    start_trip;
  endsequence
  sequence s_trip_issue;
    state_ff == bwm_pkg::M_REQ && step_ff == 4'h0 ##1 state_ff == bwm_pkg::M_WAIT;
  endsequence

  trip_capture_a: assert property (trip_rise |=> cap_ff[2] == $past(phase_current[2]))
    else $error("pole current not captured on trip");
  trip_job_a: assert property (s_trip_start |=> s_trip_issue)
    else $error("trip did not start the wear calculation");
  alarm_level_a: assert property (resetn |=> alarm_two_out == $past(min_ops[1] < lim_eff[1]))
    else $error("alarm two level wrong");
  rise_event_a: assert property (alarm_one_rise_event |->
    alarm_one_out && !$past(alarm_one_out) && $past(alarm_one_rise_event_en))
    else $error("alarm one rise event without cause");
  fall_event_a: assert property ((alarm_two_out && !alarm_two_fall_event_en) |=>
    !alarm_two_fall_event)
    else $error("alarm two fall event while disabled");
  sat_zero_a: assert property (!apply_clear |=> ops_ff[0][0] <= $past(ops_ff[0][0]))
    else $error("counter rose without clear");
  unit_dec_a: assert property ((apply_trip && step_ff == 4'h7 && below_sel
    && ops_ff[0][2] != 17'h0) |=> ops_ff[0][2] == $past(ops_ff[0][2]) - 17'h1)
    else $error("low current did not take exactly one");
  clear_load_a: assert property (apply_clear |=> ops_ff[1][2] == $past(cnt_a_ff[1]))
    else $error("clear did not reload counter");
  min_select_a: assert property (min_ops[0] <= ops_ff[0][0] && min_ops[0] <= ops_ff[0][1]
    && min_ops[0] <= ops_ff[0][2])
    else $error("minimum of phases wrong");
  limit_range_a: assert property (lim_eff[1] >= `BWM_LIM_MIN && lim_eff[1] <= `BWM_LIM_MAX)
    else $error("limit outside range");

  // a clear job opens with a calculator request
  sequence s_clear_start;
    start_clr;
  endsequence
  sequence s_clear_issue;
    state_ff == bwm_pkg::M_REQ && job_ff == bwm_pkg::JOB_CLEAR
    ##1 state_ff == bwm_pkg::M_WAIT;
  endsequence

  clear_job_a: assert property (s_clear_start |=> s_clear_issue)
    else $error("clear did not start");
  clear_all_a: assert property (apply_clear |=> ops_ff[0][1] == $past(cnt_a_ff[0]))
    else $error("counter not reloaded");
  alarm_one_level_a: assert property (resetn |=>
    alarm_one_out == $past(min_ops[0] < lim_eff[0]))
    else $error("alarm one level wrong");
  fall_one_a: assert property (alarm_one_fall_event |->
    !alarm_one_out && $past(alarm_one_out) && $past(alarm_one_fall_event_en))
    else $error("alarm one fall event without cause");
  rise_two_a: assert property (alarm_two_rise_event |->
    alarm_two_out && !$past(alarm_two_out) && $past(alarm_two_rise_event_en))
    else $error("alarm two rise event without cause");
  capture_hold_a: assert property (!trip_rise |=>
    last_break_current[1] == $past(last_break_current[1]))
    else $error("pole current changed without trip");
  trip_pend_a: assert property (trip_rise |=> trip_pend_ff)
    else $error("trip not kept pending");
  ratio_dec_a: assert property ((apply_trip && step_ff == 4'h8 && !below_sel
    && ops_ff[1][0] > delta_ff) |=> ops_ff[1][0] == $past(ops_ff[1][0]) - $past(delta_ff))
    else $error("counter not reduced by the count ratio");
  sat_floor_a: assert property ((apply_trip && step_ff == `BWM_STEP_LAST && !below_sel
    && delta_ff >= ops_ff[1][2]) |=> ops_ff[1][2] == 17'h00000)
    else $error("counter did not stop at zero");
  trip_done_a: assert property (s_trip_start |-> ##[1:1000] !busy)
    else $error("wear update did not finish");
  cur_clamp_a: assert property (alarm_eff[0] <= `BWM_CUR_MAX
    && alarm_eff[1] <= `BWM_CUR_MAX)
    else $error("alarm current outside range");
endmodule // breaker_wear_monitor
`default_nettype wire

//--- relay_bank_model.sv
// trip relay bank that closes one relay for a few cycles on request
`timescale 1ns/1ns
`default_nettype none
module relay_bank_model #(parameter int HOLD_CYCLES = 6) (
  input  wire logic       clock,
  input  wire logic       fire,
  input  wire logic [2:0] fire_idx,
  output logic [7:0]      trip_outputs
);
  int         hold_ff = 0;
  logic [2:0] idx_ff  = 3'h0;
  always_ff @(posedge clock) begin
    if (fire) begin
      idx_ff  <= fire_idx;
      hold_ff <= HOLD_CYCLES;
    end else if (hold_ff != 0) begin
      hold_ff <= hold_ff - 1;
    end
  end
  // an open relay reads low
  assign trip_outputs = (hold_ff != 0) ? (8'h01 << idx_ff) : 8'h00;
endmodule // relay_bank_model
`default_nettype wire

//--- breaker_wear_monitor_test.sv
// self-checking bench of the breaker wear monitor
`timescale 1ns/1ns
`default_nettype none
`include "bwm_defs.svh"
module breaker_wear_monitor_test;
  logic              clock = 1'b0;
  logic              resetn = 1'b0;
  logic              fire = 1'b0;
  logic [2:0]        fire_idx = 3'h0;
  logic [2:0]        trip_sel = 3'h1;
  logic [7:0]        trip_outputs;
  logic [3:0]        ev_en = 4'h0;
  logic              clear_cmd = 1'b0;
  bwm_pkg::current_t ph_cur [3] = '{default: 14'h0000};
  bwm_pkg::current_t crv_cur [8] = '{14'h0000, 14'h007d, 14'h0c1c, 14'h2710, 14'h2710,
                                     14'h2710, 14'h2710, 14'h2710};
  bwm_pkg::count_t   crv_cnt [8] = '{17'h02710, 17'h02710, 17'h00050, 17'h00001, 17'h00001,
                                     17'h00001, 17'h00001, 17'h00001};
  bwm_pkg::current_t al_cur [2] = '{14'h0258, 14'h007d};
  bwm_pkg::count_t   al_lim [2] = '{17'h00032, 17'h0270f};
  bwm_pkg::count_t   ops1 [3];
  bwm_pkg::count_t   ops2 [3];
  bwm_pkg::current_t lbc [3];
  logic              a1, a2, e1r, e1f, e2r, e2f, busy;
  int                n_ev [4] = '{default: 0};
  int                n_fail = 0;
  int                samples_checked = 0;
  int                cycles = 0;

  always #10 clock = ~clock;

  relay_bank_model relays (.clock(clock), .fire(fire), .fire_idx(fire_idx),
                           .trip_outputs(trip_outputs));
  breaker_wear_monitor dut (
    .clock(clock), .resetn(resetn), .trip_outputs(trip_outputs),
    .supervised_trip_output_select(trip_sel), .phase_current(ph_cur),
    .curve_current(crv_cur), .curve_count(crv_cnt), .alarm_current(al_cur),
    .alarm_limit(al_lim), .alarm_one_rise_event_en(ev_en[3]),
    .alarm_one_fall_event_en(ev_en[2]), .alarm_two_rise_event_en(ev_en[1]),
    .alarm_two_fall_event_en(ev_en[0]), .clear_cmd(clear_cmd),
    .ops_left_alarm_one_phase(ops1), .ops_left_alarm_two_phase(ops2),
    .last_break_current(lbc), .alarm_one_out(a1), .alarm_two_out(a2),
    .alarm_one_rise_event(e1r), .alarm_one_fall_event(e1f),
    .alarm_two_rise_event(e2r), .alarm_two_fall_event(e2f), .busy(busy));

  ////////////////////////////////////////////////////////////////////////////////
  // event pulse tally and hang guard
  always @(posedge clock) begin
    if (e1r === 1'b1) n_ev[3]++;
    if (e1f === 1'b1) n_ev[2]++;
    if (e2r === 1'b1) n_ev[1]++;
    if (e2f === 1'b1) n_ev[0]++;
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      report_and_stop();
    end
  end

  task automatic check_val(input logic [16:0] got, input logic [16:0] exp, input int tol);
    samples_checked++;
    if ($isunknown(got) || got > exp + tol || got + tol < exp) begin
      n_fail++;
      $display("Error at %0t: value %0d, expected %0d", $time, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: flag %b, expected %b", $time, got, exp);
    end
  endtask

  task automatic wait_idle();
    repeat (6) @(posedge clock);
    for (int i = 0; i < 3000 && busy !== 1'b0; i++) @(negedge clock);
    repeat (2) @(negedge clock);
    check_bit(busy, 1'b0);
  endtask

  task automatic do_trip(input bwm_pkg::current_t c0, c1, c2, input logic [2:0] relay);
    @(posedge clock);
    ph_cur   <= '{c0, c1, c2};
    fire_idx <= relay;
    fire     <= 1'b1;
    @(posedge clock);
    fire <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset();
    repeat (3) @(negedge clock);
    check_val(ops1[0], 17'h00000, 0);
    check_bit(a1, 1'b1);
    check_bit(a2, 1'b1);
  endtask

  task automatic t_clear();
    @(posedge clock);
    ev_en     <= 4'b0110;
    clear_cmd <= 1'b1;
    @(posedge clock);
    clear_cmd <= 1'b0;
    wait_idle();
    for (int p = 0; p < 3; p++) begin
      check_val(ops1[p], 17'h003b1, 1);
      check_val(ops2[p], 17'h02710, 1);
    end
    check_bit(a1, 1'b0);
    check_val(17'(n_ev[2]), 17'h00001, 0);
    check_val(17'(n_ev[0]), 17'h00000, 0);
  endtask

  task automatic t_trip();
    do_trip(14'h04e2, 14'h04e2, 14'h0096, 3'h1);
    wait_idle();
    check_val(17'(lbc[0]), 17'h004e2, 0);
    check_val(17'(lbc[2]), 17'h00096, 0);
    check_val(ops1[0], 17'h003ae, 2);
    check_val(ops1[2], 17'h003b0, 2);
    check_val(ops2[1], 17'h026f0, 2);
    check_val(ops2[2], 17'h0270f, 2);
    check_bit(a2, 1'b1);
    check_val(17'(n_ev[1]), 17'h00001, 0);
  endtask

  task automatic t_other_relay();
    do_trip(14'h0010, 14'h0010, 14'h0010, 3'h2);
    repeat (10) @(negedge clock);
    check_bit(busy, 1'b0);
    check_val(17'(lbc[0]), 17'h004e2, 0);
  endtask

  task automatic t_saturate();
    @(posedge clock);
    trip_sel <= 3'h3;
    do_trip(14'h2710, 14'h2710, 14'h2710, 3'h3);
    wait_idle();
    check_val(17'(lbc[1]), 17'h02710, 0);
    for (int p = 0; p < 3; p++) begin
      check_val(ops1[p], 17'h00000, 0);
      check_val(ops2[p], 17'h00000, 0);
    end
    check_bit(a1, 1'b1);
    check_val(17'(n_ev[3]), 17'h00000, 0);
  endtask

  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge clock);
    resetn <= 1'b1;
    t_reset();
    t_clear();
    t_trip();
    t_other_relay();
    t_saturate();
    report_and_stop();
  end
endmodule // breaker_wear_monitor_test
`default_nettype wire
